// ---- src/pmrs_top.sv ----
// power-mode, reset and base-clock sequencer of the transceiver core
`timescale 1ns/1ps
`default_nettype none
module pmrs_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // wake pins and analog monitors
    input wire logic power_on_pin_i,
    input wire logic push_button_pin_n_i,
    input wire logic core_supply_good_i,
    input wire logic osc_amplitude_ok_i,
    // serial access port
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [4:0] acc_addr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic off_cmd_i,
    output logic [7:0] acc_rdata_o,
    output logic acc_rvalid_o,
    // supplies and mode
    output logic analog_supply_en_o,
    output logic core_supply_en_o,
    output logic core_reset_o,
    output logic osc_ready_o,
    output logic idle_mode_o,
    output logic rf_enable_o,
    output logic [2:0] operating_mode_o,
    // interrupt and status
    output logic irq_o,
    output logic [7:0] status_o,
    // derived clocks
    output logic base_clk_tick_o,
    output logic bit_clk_tick_o,
    output logic clk_out_o
);

    // bit period in base ticks; a zero limit acts as one
    function automatic logic [10:0] bit_period(
        input logic [7:0] xlim,
        input logic [1:0] range
    );
        logic [10:0] lim;
        lim = {3'h0, (xlim == 8'h00) ? pmrs_pkg::XLIM_MIN : xlim};
        bit_period = lim << (pmrs_pkg::BRR_SHIFT_MAX - range);
    endfunction

    pmrs_mem_if mem_bus ();

    pmrs_regmem u_regmem (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .bus(mem_bus.mem)
    );

    // pin synchronisers
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] pins_r;
    wire [3:0] pins_raw = {osc_amplitude_ok_i, core_supply_good_i,
                           push_button_pin_n_i, power_on_pin_i};
    wire [3:0] pins_agree = ~(sync2_r ^ sync3_r);
    wire [3:0] pins_nxt = (sync3_r & pins_agree) | (pins_r & ~pins_agree);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_r <= pmrs_pkg::PINS_RESET;
            sync2_r <= pmrs_pkg::PINS_RESET;
            sync3_r <= pmrs_pkg::PINS_RESET;
            pins_r <= pmrs_pkg::PINS_RESET;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pins_r <= pins_nxt;
        end
    end

    wire power_on_pin = pins_r[0];
    wire push_n = pins_r[1];
    wire sup_good = pins_r[2];
    wire amp_ok = pins_r[3];
    wire wake_req = power_on_pin || !push_n;

    // mode sequencing
    pmrs_pkg::pmrs_mode_t mode_r;
    pmrs_pkg::pmrs_mode_t mode_nxt;
    logic core_reset_r;
    logic supply_en_r;
    logic osc_ready_r;

    wire is_off = (mode_r == pmrs_pkg::PMRS_OFF);
    wire is_active = (mode_r == pmrs_pkg::PMRS_ACTIVE);
    // loss of the core supply only drops to off with the wake pins parked
    wire supply_lost = !sup_good && push_n && !power_on_pin;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            pmrs_pkg::PMRS_OFF: begin
                if (wake_req)
                    mode_nxt = pmrs_pkg::PMRS_RAMP;
            end
            pmrs_pkg::PMRS_RAMP: begin
                if (sup_good)
                    mode_nxt = pmrs_pkg::PMRS_ACTIVE;
            end
            pmrs_pkg::PMRS_ACTIVE: begin
                if (off_cmd_i)
                    mode_nxt = pmrs_pkg::PMRS_OFF;
                else if (supply_lost)
                    mode_nxt = pmrs_pkg::PMRS_OFF;
            end
            default: mode_nxt = pmrs_pkg::PMRS_OFF;
        endcase
    end

    wire wake_event = is_off && (mode_nxt == pmrs_pkg::PMRS_RAMP);
    // mode flags follow the next mode so they drop with the supplies
    wire next_active = (mode_nxt == pmrs_pkg::PMRS_ACTIVE);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_r <= pmrs_pkg::PMRS_OFF;
            core_reset_r <= 1'b1;
            supply_en_r <= 1'b0;
            osc_ready_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            core_reset_r <= (mode_nxt != pmrs_pkg::PMRS_ACTIVE);
            supply_en_r <= (mode_nxt != pmrs_pkg::PMRS_OFF);
            // the detector decides when the swing is large enough
            osc_ready_r <= !is_off && amp_ok;
        end
    end

    // access decode; nothing is taken while off or in reset
    wire acc_ok = acc_valid_i && is_active && !core_reset_r;
    wire addr_is_mem = !(acc_addr_i[4] && acc_addr_i[3]);
    wire addr_is_status = (acc_addr_i == pmrs_pkg::STATUS_ADDR);
    wire mem_rd = acc_ok && !acc_write_i && addr_is_mem;
    wire stat_rd = acc_ok && !acc_write_i && addr_is_status;

    assign mem_bus.clr = core_reset_r;
    assign mem_bus.we = acc_ok && acc_write_i && addr_is_mem;
    assign mem_bus.addr = acc_addr_i;
    assign mem_bus.wdata = acc_wdata_i;

    // control fields
    wire [7:0] ctrl_opm = mem_bus.ctrl[pmrs_pkg::OPM_REG*8 +: 8];
    wire [2:0] operating_mode_field = ctrl_opm[pmrs_pkg::OPM_LSB +: 3];
    wire [7:0] ctrl_clk = mem_bus.ctrl[pmrs_pkg::CLKEN_REG*8 +: 8];
    wire clk_enable = ctrl_clk[pmrs_pkg::CLKEN_BIT];
    wire [7:0] xlim = mem_bus.ctrl[pmrs_pkg::XLIM_REG*8 +: 8];
    wire [7:0] ctrl_brr = mem_bus.ctrl[pmrs_pkg::BRR_REG*8 +: 8];
    wire [1:0] brr = ctrl_brr[pmrs_pkg::BRR_LSB +: 2];
    wire opm_idle = (operating_mode_field == pmrs_pkg::OPM_IDLE);

    // status flags
    logic pon_flag_r;
    logic push_flag_r;
    logic rst_flag_r;
    logic irq_r;
    wire rst_clear = stat_rd && sup_good && osc_ready_r;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pon_flag_r <= 1'b0;
            push_flag_r <= 1'b0;
            rst_flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            // the set side always beats a clear in the same cycle
            if (wake_event) begin
                pon_flag_r <= power_on_pin;
                push_flag_r <= !push_n;
                rst_flag_r <= 1'b1;
                irq_r <= 1'b1;
            end else if (is_off) begin
                pon_flag_r <= 1'b0;
                push_flag_r <= 1'b0;
                rst_flag_r <= 1'b0;
                irq_r <= 1'b0;
            end else begin
                if (stat_rd) begin
                    pon_flag_r <= 1'b0;
                    push_flag_r <= 1'b0;
                    irq_r <= 1'b0;
                end
                if (rst_clear)
                    rst_flag_r <= 1'b0;
            end
        end
    end

    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00;
        status_byte[pmrs_pkg::ST_POWER_ON_PIN_BIT] = pon_flag_r;
        status_byte[pmrs_pkg::ST_PUSH_BIT] = push_flag_r;
        status_byte[pmrs_pkg::ST_RST_BIT] = rst_flag_r;
    end

    // read pipeline: storage answers a cycle later, status is aligned
    logic rd_pend_r;
    logic rd_status_r;
    logic [7:0] status_snap_r;
    logic [7:0] acc_rdata_r;
    logic acc_rvalid_r;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_pend_r <= 1'b0;
            rd_status_r <= 1'b0;
            status_snap_r <= 8'h00;
            acc_rdata_r <= 8'h00;
            acc_rvalid_r <= 1'b0;
        end else begin
            rd_pend_r <= mem_rd || stat_rd;
            rd_status_r <= stat_rd;
            status_snap_r <= status_byte;
            acc_rvalid_r <= rd_pend_r;
            if (rd_pend_r)
                acc_rdata_r <= rd_status_r ? status_snap_r
                                           : mem_bus.rdata;
        end
    end

    // base clock and bit clock
    logic [3:0] base_cnt_r;
    logic [10:0] bit_cnt_r;
    logic base_tick_r;
    logic bit_tick_r;
    wire base_tick = (base_cnt_r == pmrs_pkg::BASE_DIV_LAST);
    wire [10:0] bit_last = bit_period(xlim, brr) - 11'h001;
    wire bit_wrap = (bit_cnt_r >= bit_last);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            base_cnt_r <= 4'h0;
            bit_cnt_r <= 11'h000;
            base_tick_r <= 1'b0;
            bit_tick_r <= 1'b0;
        end else if (core_reset_r) begin
            base_cnt_r <= 4'h0;
            bit_cnt_r <= 11'h000;
            base_tick_r <= 1'b0;
            bit_tick_r <= 1'b0;
        end else begin
            base_cnt_r <= base_cnt_r + 4'h1;
            base_tick_r <= base_tick;
            bit_tick_r <= base_tick && bit_wrap;
            if (base_tick)
                bit_cnt_r <= bit_wrap ? 11'h000
                                      : bit_cnt_r + 11'h001;
        end
    end

    // clock output to the host; duty is one third, not a true half
    logic [1:0] clk_div_r;
    logic clk_out_r;
    wire clk_allow = is_active && sup_good && osc_ready_r
                     && clk_enable;
    wire clk_div_wrap = (clk_div_r == pmrs_pkg::CLKOUT_DIV_LAST);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_div_r <= 2'h0;
            clk_out_r <= 1'b0;
        end else if (core_reset_r) begin
            clk_div_r <= 2'h0;
            clk_out_r <= 1'b0;
        end else begin
            clk_div_r <= clk_div_wrap ? 2'h0 : clk_div_r + 2'h1;
            clk_out_r <= clk_allow
                         && (clk_div_r < pmrs_pkg::CLKOUT_HIGH_LAST);
        end
    end

    // registered mode outputs
    logic idle_r;
    logic rf_en_r;
    logic [2:0] opm_r;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_r <= 1'b0;
            rf_en_r <= 1'b0;
            opm_r <= 3'h0;
        end else begin
            idle_r <= next_active && opm_idle;
            // radio stays dark until a non-idle mode is programmed
            rf_en_r <= next_active && !opm_idle;
            opm_r <= operating_mode_field;
        end
    end

    assign acc_rdata_o = acc_rdata_r;
    assign acc_rvalid_o = acc_rvalid_r;
    assign analog_supply_en_o = supply_en_r;
    assign core_supply_en_o = supply_en_r;
    assign core_reset_o = core_reset_r;
    assign osc_ready_o = osc_ready_r;
    assign idle_mode_o = idle_r;
    assign rf_enable_o = rf_en_r;
    assign operating_mode_o = opm_r;
    assign irq_o = irq_r;
    assign status_o = status_snap_r;
    assign base_clk_tick_o = base_tick_r;
    assign bit_clk_tick_o = bit_tick_r;
    assign clk_out_o = clk_out_r;
endmodule // pmrs_top
`default_nettype wire

// ---- src/pmrs_pkg.sv ----
// constants and types of the power-mode and reset sequencer
// Functional notes
// - base clock is crystal clock divided by sixteen
// - polling bit-check and transmit rate use base clock
// - bit period is base times limit times 8/4/2/1
// - power-up enters off mode, both supplies disconnected
// - serial accesses ignored while in off mode
// - power-on high or push-button low wakes to idle
// - wake raises interrupt and flags the waking pin
// - idle keeps radio off, accepts parameter and mode writes
// - serial off command returns idle to off
// - operating-mode field all zero selects idle
// - switch-on reset clears logic, loads defaults, sets flag
// - clock output only after supply good and oscillator ready
// - reset flag clears on status read after both ready
// - supply loss with wake pins inactive forces off mode
// - sixteen byte buffer and eight control registers
// - separate readable eight bit status register
// - storage kept while active, lost in off mode
// - clock output disabled while clock-enable bit is zero
// - oscillator ready only after amplitude detector agrees
package pmrs_pkg;
    // base clock divider: 16 crystal cycles per base tick
    localparam logic [3:0] BASE_DIV_LAST = 4'hf;
    // clock output divider: 3 crystal cycles per period
    localparam logic [1:0] CLKOUT_DIV_LAST = 2'h2;
    localparam logic [1:0] CLKOUT_HIGH_LAST = 2'h1;
    localparam logic [1:0] BRR_SHIFT_MAX = 2'h3;
    localparam logic [7:0] XLIM_MIN = 8'h01;
    // access port address map
    localparam logic [4:0] CTRL_BASE_ADDR = 5'h10;
    localparam logic [4:0] STATUS_ADDR = 5'h18;
    // control register indices and field positions
    localparam int OPM_REG = 0;
    localparam int OPM_LSB = 0;
    localparam int CLKEN_REG = 2;
    localparam int CLKEN_BIT = 0;
    localparam int XLIM_REG = 3;
    localparam int BRR_REG = 5;
    localparam int BRR_LSB = 0;
    localparam logic [2:0] OPM_IDLE = 3'h0;
    // control defaults, register 7 in the top byte
    localparam logic [63:0] CTRL_DEFAULT = 64'h0000_0000_0001_0000;
    // status register bit positions
    localparam int ST_POWER_ON_PIN_BIT = 0;
    localparam int ST_PUSH_BIT = 1;
    localparam int ST_RST_BIT = 2;
    // synchroniser reset image: push-button idles high
    localparam logic [3:0] PINS_RESET = 4'h2;
    typedef enum logic [1:0] {
        PMRS_OFF,
        PMRS_RAMP,
        PMRS_ACTIVE
    } pmrs_mode_t;
endpackage

// ---- src/pmrs_mem_if.sv ----
// carrier between the sequencer and its storage
`timescale 1ns/1ps
`default_nettype none
interface pmrs_mem_if;
    logic clr;
    logic we;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [63:0] ctrl;
    modport host (output clr, we, addr, wdata, input rdata, ctrl);
    modport mem (input clr, we, addr, wdata, output rdata, ctrl);
endinterface
`default_nettype wire

// ---- src/pmrs_regmem.sv ----
// data buffer and control register storage
`timescale 1ns/1ps
`default_nettype none
module pmrs_regmem (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // storage port
    pmrs_mem_if.mem bus
);
    logic [7:0] buf_r [16];
    logic [63:0] ctrl_r;
    logic [7:0] rdata_r;
    wire is_ctrl = bus.addr[4];
    wire [5:0] ctrl_lsb = {bus.addr[2:0], 3'h0};

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 16; i++) buf_r[i] <= 8'h00;
            ctrl_r <= pmrs_pkg::CTRL_DEFAULT;
            rdata_r <= 8'h00;
        end else if (bus.clr) begin
            // contents vanish whenever the core is unpowered
            for (int i = 0; i < 16; i++) buf_r[i] <= 8'h00;
            ctrl_r <= pmrs_pkg::CTRL_DEFAULT;
            rdata_r <= 8'h00;
        end else begin
            if (bus.we && is_ctrl)
                ctrl_r[ctrl_lsb +: 8] <= bus.wdata;
            if (bus.we && !is_ctrl)
                buf_r[bus.addr[3:0]] <= bus.wdata;
            rdata_r <= is_ctrl ? ctrl_r[ctrl_lsb +: 8]
                               : buf_r[bus.addr[3:0]];
        end
    end

    assign bus.rdata = rdata_r;
    assign bus.ctrl = ctrl_r;
endmodule // pmrs_regmem
`default_nettype wire

// ---- tb/pmrs_top_props.sv ----
// port checker of the power-mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module pmrs_top_props (
    // clock, reset and inputs
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic power_on_pin_i,
    input wire logic push_button_pin_n_i,
    input wire logic core_supply_good_i,
    input wire logic osc_amplitude_ok_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [4:0] acc_addr_i,
    input wire logic off_cmd_i,
    // outputs
    input wire logic acc_rvalid_o,
    input wire logic analog_supply_en_o,
    input wire logic core_supply_en_o,
    input wire logic core_reset_o,
    input wire logic osc_ready_o,
    input wire logic idle_mode_o,
    input wire logic rf_enable_o,
    input wire logic irq_o,
    input wire logic [7:0] status_o,
    input wire logic base_clk_tick_o,
    input wire logic bit_clk_tick_o,
    input wire logic clk_out_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // gap counter saturates so a stalled divider still reads wrong
    logic [7:0] gap_r, gap_nxt;
    logic seen_r, seen_nxt;
    assign gap_nxt = base_clk_tick_o ? 8'h01 :
        (gap_r == 8'hff ? gap_r : gap_r + 8'h01);
    assign seen_nxt = !core_reset_o && (seen_r || base_clk_tick_o);
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_r <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            gap_r <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end
    AST_BASE_GAP: assert property (
        base_clk_tick_o && seen_r && !core_reset_o |-> gap_r == 8'h10)
        else $error("base tick spacing wrong");
    AST_HELD_RST: assert property (
        core_reset_o && $past(core_reset_o) |->
        !base_clk_tick_o && !bit_clk_tick_o)
        else $error("divider ticks during core reset");
    AST_READ_ANS: assert property (
        acc_valid_i && !acc_write_i && acc_addr_i <= 5'h18 &&
        core_supply_en_o && !core_reset_o |-> ##2 acc_rvalid_o)
        else $error("read answer missing");
    AST_OFF_DEAF: assert property (
        acc_valid_i && core_reset_o |-> ##2 !acc_rvalid_o)
        else $error("access answered while off");
    AST_OFF_SUPPLY: assert property (
        !core_supply_en_o |-> !analog_supply_en_o && core_reset_o &&
        !idle_mode_o && !rf_enable_o)
        else $error("off mode outputs wrong");
    AST_WAKE_IRQ: assert property (
        $rose(core_supply_en_o) |-> irq_o ##1
        (status_o[2] && |status_o[1:0]))
        else $error("wake without interrupt or flags");
    AST_OFF_CMD: assert property (
        off_cmd_i && core_supply_en_o && !core_reset_o |=>
        !core_supply_en_o && core_reset_o)
        else $error("off command not obeyed");
    AST_IDLE_RF: assert property (
        idle_mode_o |-> !rf_enable_o && core_supply_en_o)
        else $error("radio on in idle");
    AST_CLK_GATE: assert property (
        clk_out_o |-> osc_ready_o || $past(osc_ready_o))
        else $error("clock output before oscillator ready");
    AST_CLK_DUTY: assert property (
        clk_out_o |=> (!clk_out_o) [*2])
        else $error("clock output shape wrong");
    AST_OSC_WAIT: assert property (
        (!osc_amplitude_ok_i) [*6] |-> !osc_ready_o)
        else $error("oscillator ready without amplitude");
    AST_SUPPLY_LOSS: assert property (
        (!core_supply_good_i && !power_on_pin_i &&
        push_button_pin_n_i) [*7] |-> core_reset_o)
        else $error("supply loss did not force off");
    cover property ($rose(core_supply_en_o));
    cover property (acc_rvalid_o);
    cover property ($fell(core_supply_en_o));
    cover property (bit_clk_tick_o);
endmodule // pmrs_top_props
`default_nettype wire

// ---- tb/pmrs_host_model.sv ----
// host microcontroller model driving the access port and wake pins
`timescale 1ns/1ps
`default_nettype none
module pmrs_host_model (
    // clock and read answer
    input wire logic ref_clk_i,
    input wire logic rvalid_i,
    input wire logic [7:0] rdata_i,
    // requests and pins
    output logic valid_o,
    output logic write_o,
    output logic [4:0] addr_o,
    output logic [7:0] wdata_o,
    output logic off_cmd_o,
    output logic power_on_o,
    output logic push_n_o
);
    initial begin
        valid_o = 1'b0;
        write_o = 1'b0;
        addr_o = 5'h00;
        wdata_o = 8'h00;
        off_cmd_o = 1'b0;
        power_on_o = 1'b0;
        push_n_o = 1'b1;
    end
    // released lines flip so a stale value is never taken for data
    task automatic req(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        @(negedge ref_clk_i);
        valid_o = 1'b1;
        write_o = w;
        addr_o = a;
        wdata_o = d;
        @(negedge ref_clk_i);
        valid_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        req(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d,
                      output logic got);
        req(1'b0, a, 8'h00);
        @(negedge ref_clk_i);
        got = rvalid_i;
        d = rdata_i;
    endtask
    task automatic pins(input logic p, input logic n);
        @(negedge ref_clk_i);
        power_on_o = p;
        push_n_o = n;
    endtask
    task automatic off();
        pins(1'b0, 1'b1);
        repeat (5) @(negedge ref_clk_i);
        off_cmd_o = 1'b1;
        @(negedge ref_clk_i);
        off_cmd_o = 1'b0;
    endtask
endmodule // pmrs_host_model
`default_nettype wire

// ---- tb/power_mode_reset_sequencer_tb.sv ----
// testbench of the power-mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITC(c) for (w = 0; w < 400 && !(c); w++) @(negedge ref_clk); \
    if ((c) !== 1'b1) num_errors++;
module power_mode_reset_sequencer_tb;
    logic ref_clk, reset_n, sgood, osc_ok, pon, pbn, valid, wr_en, offc;
    logic rvalid, aen, cen, crst, oscr, idle, rf, irq, btk, bitt, clko;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, status, d;
    logic [2:0] operating_mode_field;
    logic got;
    int num_errors = 0;
    int tests_run = 0;
    int w, i, n;
    logic [7:0] xl [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00};
    logic [1:0] rg [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    pmrs_top dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
        .power_on_pin_i(pon), .push_button_pin_n_i(pbn),
        .core_supply_good_i(sgood), .osc_amplitude_ok_i(osc_ok),
        .acc_valid_i(valid), .acc_write_i(wr_en), .acc_addr_i(addr),
        .acc_wdata_i(wdata), .off_cmd_i(offc), .acc_rdata_o(rdata),
        .acc_rvalid_o(rvalid), .analog_supply_en_o(aen),
        .core_supply_en_o(cen), .core_reset_o(crst),
        .osc_ready_o(oscr), .idle_mode_o(idle), .rf_enable_o(rf),
        .operating_mode_o(operating_mode_field), .irq_o(irq), .status_o(status),
        .base_clk_tick_o(btk), .bit_clk_tick_o(bitt), .clk_out_o(clko));
    pmrs_host_model host (.ref_clk_i(ref_clk), .rvalid_i(rvalid),
        .rdata_i(rdata), .valid_o(valid), .write_o(wr_en),
        .addr_o(addr), .wdata_o(wdata), .off_cmd_o(offc),
        .power_on_o(pon), .push_n_o(pbn));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic per(output int k);
        `WAITC(bitt)
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (!bitt && k < 3000);
    endtask
    task automatic highs(output int k);
        k = 0;
        repeat (4) @(negedge ref_clk);
        repeat (30) begin
            @(negedge ref_clk);
            k += int'(clko);
        end
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("watchdog expired");
        results();
    end
    initial begin
        reset_n = 1'b0;
        sgood = 1'b1;
        osc_ok = 1'b0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        `CHK({cen, crst}, 2'h1)
        host.rd(5'h12, d, got);
        `CHK(got, 1'b0)
        $display("test off done");
        host.pins(1'b1, 1'b1);
        `WAITC(cen)
        `CHK({irq, aen}, 2'h3)
        `WAITC(!crst)
        host.pins(1'b0, 1'b1);
        `CHK(status, 8'h05)
        `CHK({idle, rf, operating_mode_field}, 5'h10)
        for (i = 0; i < 8; i++) begin
            host.rd(5'h10 + 5'(i), d, got);
            `CHK(d, pmrs_pkg::CTRL_DEFAULT[8*i +: 8])
        end
        host.rd(pmrs_pkg::STATUS_ADDR, d, got);
        `CHK({d, irq}, 9'h0a)
        host.rd(pmrs_pkg::STATUS_ADDR, d, got);
        `CHK(d, 8'h04)
        osc_ok = 1'b1;
        `WAITC(oscr)
        host.rd(pmrs_pkg::STATUS_ADDR, d, got);
        `CHK(d, 8'h04)
        host.rd(pmrs_pkg::STATUS_ADDR, d, got);
        `CHK(d, 8'h00)
        $display("test wake done");
        highs(n);
        `CHK(n, 10)
        host.wr(5'h12, 8'h00);
        highs(n);
        `CHK(n, 0)
        host.wr(5'h12, 8'h01);
        for (i = 0; i < 16; i++) host.wr(5'(i), 8'ha5 ^ 8'(i));
        for (i = 0; i < 16; i++) begin
            host.rd(5'(i), d, got);
            `CHK({got, d}, {1'b1, 8'ha5 ^ 8'(i)})
        end
        host.wr(pmrs_pkg::STATUS_ADDR, 8'hff);
        host.rd(pmrs_pkg::STATUS_ADDR, d, got);
        `CHK(d, 8'h00)
        host.rd(5'h19, d, got);
        `CHK(got, 1'b0)
        host.wr(5'h10, 8'h01);
        repeat (3) @(negedge ref_clk);
        `CHK({idle, rf, operating_mode_field}, 5'h09)
        host.wr(5'h10, 8'h00);
        repeat (3) @(negedge ref_clk);
        `CHK({idle, rf, operating_mode_field}, 5'h10)
        $display("test storage done");
        for (i = 0; i < 5; i++) begin
            host.wr(5'h13, xl[i]);
            host.wr(5'h15, {6'h00, rg[i]});
            per(n);
            per(n);
            `CHK(n, 16 * (xl[i] == 0 ? 1 : xl[i]) * (8 >> rg[i]))
        end
        $display("test bit rate done");
        host.off();
        `WAITC(!cen)
        `CHK({aen, cen, crst}, 3'h1)
        host.pins(1'b0, 1'b0);
        `WAITC(!crst)
        host.pins(1'b0, 1'b1);
        `CHK(status, 8'h06)
        host.rd(5'h00, d, got);
        `CHK(d, 8'h00)
        sgood = 1'b0;
        `WAITC(!cen)
        `CHK({cen, crst}, 2'h1)
        $display("test off and loss done");
        results();
    end
endmodule // power_mode_reset_sequencer_tb
bind pmrs_top pmrs_top_props u_props (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .power_on_pin_i(power_on_pin_i),
    .push_button_pin_n_i(push_button_pin_n_i),
    .core_supply_good_i(core_supply_good_i),
    .osc_amplitude_ok_i(osc_amplitude_ok_i), .acc_valid_i(acc_valid_i),
    .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
    .off_cmd_i(off_cmd_i), .acc_rvalid_o(acc_rvalid_o),
    .analog_supply_en_o(analog_supply_en_o),
    .core_supply_en_o(core_supply_en_o), .core_reset_o(core_reset_o),
    .osc_ready_o(osc_ready_o), .idle_mode_o(idle_mode_o),
    .rf_enable_o(rf_enable_o), .irq_o(irq_o), .status_o(status_o),
    .base_clk_tick_o(base_clk_tick_o), .bit_clk_tick_o(bit_clk_tick_o),
    .clk_out_o(clk_out_o));
`default_nettype wire
